//--- enhanced_watchdog_timer_tb_top.sv
`timescale 1ns/10ps

`define chk(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end

// ============================================================
// watchdog core testbench
module enhanced_watchdog_timer_tb_top;
  logic clk, rst, always_on_fuse, ctrl_wr, watchdog_reset_flag, irq, sys_reset, seen, hit;
  logic [7:0] ctrl_wdata, ctrl_rdata;
  logic [3:0] pl;
  int error_cnt, comparisons, cyc, cnt;

  // fast oscillator divide keeps expiry near 4096 clocks
  ewd_core #(.OSC_DIV(2)) ewd_core_i (.clk(clk), .rst(rst), .always_on_fuse(always_on_fuse), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .restart(pl[0]), .vector_ack(pl[1]), .reset_flag_clr(pl[2]), .reset_flag_in(pl[3]),
    .ctrl_rdata(ctrl_rdata), .watchdog_reset_flag(watchdog_reset_flag), .irq(irq), .sys_reset(sys_reset));

  always #20 clk = ~clk;

  // remember any reset pulse and cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sys_reset === 1'b1) seen <= 1'b1;
    if (cyc == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge clk); ctrl_wr <= 1'b1; ctrl_wdata <= d;
    @(posedge clk); ctrl_wr <= 1'b0; #1;
  endtask

  task automatic pulse(input int i);
    @(posedge clk); pl[i] <= 1'b1;
    @(posedge clk); pl <= 4'h0; #1;
  endtask

  // wait for sys_reset (rs) or irq, bounded
  task automatic wait_ev(input bit rs);
    cnt = 0;
    while ((rs ? sys_reset : irq) !== 1'b1 && cnt < 5000) begin
      @(posedge clk); #1; cnt++;
    end
    hit = (cnt < 5000);
  endtask

  task automatic t_irq();
    seen = 0; wr(8'h40); wait_ev(0);
    `chk({hit, seen, ctrl_rdata}, 10'h2C0)
    pulse(1);
    `chk({irq, ctrl_rdata}, 9'h040)
    wait_ev(0); wr(8'hC0);
    `chk({hit, irq, ctrl_rdata}, 10'h240)
    wr(8'h00);
  endtask

  task automatic t_comb();
    seen = 0; wr(8'h48); wait_ev(0);
    `chk({hit, seen, ctrl_rdata}, 10'h2C8)
    pulse(1);
    `chk({irq, ctrl_rdata}, 9'h008)
    wait_ev(1);
    `chk({hit, ctrl_rdata[3]}, 2'h3)
  endtask

  task automatic t_unlock();
    pulse(2);
    wr(8'h00); `chk(ctrl_rdata, 8'h08)
    wr(8'h18); `chk(ctrl_rdata, 8'h18)
    wr(8'h03); `chk(ctrl_rdata, 8'h03)
    wr(8'h01); `chk(ctrl_rdata, 8'h03)
    wr(8'h1B); repeat (6) @(posedge clk);
    wr(8'h00); `chk(ctrl_rdata, 8'h0B)
    wr(8'h1B); wr(8'h00); `chk(ctrl_rdata, 8'h00)
  endtask

  task automatic t_flag();
    pulse(3); wr(8'h18); wr(8'h00);
    `chk({watchdog_reset_flag, ctrl_rdata}, 9'h108)
    pulse(2); wr(8'h18); wr(8'h00);
    `chk({watchdog_reset_flag, ctrl_rdata}, 9'h000)
  endtask

  task automatic t_fuse();
    @(posedge clk); always_on_fuse <= 1'b1;
    pulse(0); wr(8'h40); `chk(ctrl_rdata, 8'h08)
    wr(8'h18); wr(8'h00); `chk(ctrl_rdata, 8'h08)
    seen = 0;
    repeat (3) begin
      repeat (3000) @(posedge clk);
      pulse(0);
    end
    `chk(seen, 1'b0)
    wait_ev(1);
    `chk(cnt > 4085 && cnt < 4105, 1'b1)
  endtask

  // ============================================================
  // main sequence
  initial begin
    clk = 0; rst = 1; always_on_fuse = 0; ctrl_wr = 0; ctrl_wdata = 8'h00; pl = 4'h0;
    seen = 0; error_cnt = 0; comparisons = 0; cyc = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0; #1;
    `chk({watchdog_reset_flag, irq, sys_reset, ctrl_rdata}, 11'h000)
    t_irq(); t_comb(); t_unlock(); t_flag(); t_fuse();
    tally_and_finish();
  end
endmodule // enhanced_watchdog_timer_tb_top

//--- ewd_checker.sv
`timescale 1ns/10ps

// ============================================================
// port-level checks for the watchdog core
module ewd_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs
  input wire logic always_on_fuse,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic vector_ack,
  // outputs
  input wire logic [7:0] ctrl_rdata,
  input wire logic watchdog_reset_flag,
  input wire logic irq,
  input wire logic sys_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ============================================================
  // assertions
  a_pulse_one_cycle: assert property (sys_reset |=> !sys_reset)
    else $error("reset pulse longer than one cycle");
  a_fuse_locks_bits: assert property (always_on_fuse && $past(always_on_fuse, 2) |-> ctrl_rdata[3] && !ctrl_rdata[6])
    else $error("fuse does not lock enables");
  a_flag_forces_en: assert property (watchdog_reset_flag && $past(watchdog_reset_flag) |-> ctrl_rdata[3])
    else $error("reset flag does not force enable");
  a_irq_has_cause: assert property (irq |-> ctrl_rdata[7] && ctrl_rdata[6])
    else $error("irq without flag and enable");
  a_unlock_self_clear: assert property ($rose(ctrl_rdata[4]) |-> ##[1:4] !ctrl_rdata[4])
    else $error("unlock bit stays too long");
  a_en_clear_locked: assert property (ctrl_wr && !ctrl_wdata[3] && ctrl_rdata[3] && !ctrl_rdata[4] |=> ctrl_rdata[3])
    else $error("enable cleared without unlock");
  a_sel_locked: assert property (ctrl_wr && !ctrl_rdata[4] |=> $stable({ctrl_rdata[5], ctrl_rdata[2:0]}))
    else $error("select changed without unlock");
  a_reset_cause: assert property (sys_reset |-> $past(ctrl_rdata[3]) && !$past(ctrl_rdata[6] && !ctrl_rdata[7]))
    else $error("reset in a mode that forbids it");
  a_vector_clears: assert property (vector_ack && ctrl_rdata[3] && !ctrl_wr |=> !ctrl_rdata[6] && !irq)
    else $error("vector did not drop irq enable");

  // main scenarios reached
  c_reset: cover property (sys_reset);
  c_irq: cover property (irq);
  c_unlock: cover property ($rose(ctrl_rdata[4]));
endmodule // ewd_checker

bind ewd_core ewd_checker ewd_checker_i (.clk(clk), .rst(rst), .always_on_fuse(always_on_fuse), .ctrl_wr(ctrl_wr),
  .ctrl_wdata(ctrl_wdata), .vector_ack(vector_ack), .ctrl_rdata(ctrl_rdata),
  .watchdog_reset_flag(watchdog_reset_flag), .irq(irq), .sys_reset(sys_reset));

//--- ewd_core.sv
`timescale 1ns/10ps

// Notes on behaviour
// - counter advances on oscillator ticks only
// - expiry gives interrupt or reset per mode
// - restart instruction clears counter to zero
// - ten periods selectable, 2K to 1024K ticks
// - interrupt mode flags interrupt, no reset
// - reset mode pulses system reset on expiry
// - combined mode: interrupt first, then reset
// - fuse forces reset mode
// - fuse holds reset enable one, irq enable zero
// - clearing enable or new select needs unlock
// - enable stays set after watchdog reset
// - unlock bit self-clears after four cycles
// - reset flag forces enable to one
// - irq flag set on expiry, cleared by vector/one
// - combined-mode vector clears irq enable and flag
module ewd_core import ewd_pkg::*; #(
  parameter int OSC_DIV = (CLK_KHZ + OSC_KHZ - 1) / OSC_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fuse, programmed when high
  input wire logic always_on_fuse,
  // control write port
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  // restart instruction and vector execution
  input wire logic restart,
  input wire logic vector_ack,
  // reset flag register interface
  input wire logic reset_flag_clr,
  input wire logic reset_flag_in,
  // status outputs
  output logic [7:0] ctrl_rdata,
  output logic watchdog_reset_flag,
  output logic irq,
  output logic sys_reset
);

  // ==========================================================================
  // state
  logic reset_mode_enable_reg;
  logic reset_mode_enable_next;
  logic timeout_irq_enable_reg;
  logic timeout_irq_enable_next;
  logic timeout_irq_flag_reg;
  logic timeout_irq_flag_next;
  logic [3:0] timeout_select_field_reg;
  logic [3:0] timeout_select_field_next;
  logic change_unlock_bit_reg;
  logic [2:0] unlock_cnt_reg;
  logic [2:0] unlock_cnt_next;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic reset_flag_reg;
  logic reset_flag_next;
  logic irq_next;
  logic [7:0] rdata_next;
  logic osc_tick;
  ewd_mode_type mode;

  // ==========================================================================
  // oscillator tick source
  ewd_osc_tick #(
    .DIV(OSC_DIV)
  ) ewd_osc_tick_i (
    .clk(clk),
    .rst(rst),
    .tick(osc_tick)
  );

  // ==========================================================================
  // write decode
  wire wr_unlock = ctrl_wdata[BIT_UNLOCK];
  wire wr_en = ctrl_wdata[BIT_RST_EN];
  wire wr_ie = ctrl_wdata[BIT_IRQ_EN];
  wire [3:0] wr_sel = {ctrl_wdata[BIT_SEL3], ctrl_wdata[BIT_SEL2], ctrl_wdata[BIT_SEL1], ctrl_wdata[BIT_SEL0]};
  wire start_unlock = ctrl_wr & wr_unlock & wr_en;
  wire unlocked_wr = ctrl_wr & ~wr_unlock & change_unlock_bit_reg;
  wire plain_wr = ctrl_wr & ~start_unlock & ~unlocked_wr;

  // ==========================================================================
  // operating mode

  // effective enables under the fuse, then mode decode
  wire eff_en = reset_mode_enable_reg | always_on_fuse;
  wire eff_ie = timeout_irq_enable_reg & ~always_on_fuse;
  always_comb begin
    unique case ({eff_en, eff_ie})
      2'b00: mode = ewd_stopped_type_e;
      2'b01: mode = ewd_irq_type_e;
      2'b10: mode = ewd_reset_type_e;
      2'b11: mode = ewd_both_type_e;
    endcase
  end

  // ==========================================================================
  // time-out compare against selected period
  wire [4:0] shift_amt = 5'(BASE_CYCLES_LOG2) + {1'b0, timeout_select_field_reg};
  wire [CNT_W:0] limit = (CNT_W + 1)'(1) << shift_amt;
  wire expire = osc_tick & ({1'b0, count_reg} == limit - (CNT_W + 1)'(1));
  wire running = (mode != ewd_stopped_type_e);

  // counter clears on restart, while stopped, and at expiry
  wire count_clear = restart | ~running | expire;

  // counter: advance on oscillator tick only
  assign count_next = count_clear ? '0 :
    (osc_tick ? count_reg + CNT_W'(1) : count_reg);

  // ==========================================================================
  // control bits

  // reset enable: forced by flag or fuse, cleared only via unlock
  always_comb begin
    reset_mode_enable_next = reset_mode_enable_reg;
    if (start_unlock)
      reset_mode_enable_next = 1'b1;
    else if (unlocked_wr)
      reset_mode_enable_next = wr_en;
    else if (plain_wr & wr_en)
      reset_mode_enable_next = 1'b1; // setting needs no unlock
    if (reset_flag_reg | always_on_fuse)
      reset_mode_enable_next = 1'b1;
  end

  // select changes only through unlock
  assign timeout_select_field_next = (unlocked_wr && wr_sel <= SEL_MAX) ? wr_sel :
    timeout_select_field_reg;

  // ==========================================================================
  // interrupt

  // irq enable: free write, cleared by combined-mode vector, zero under fuse
  always_comb begin
    timeout_irq_enable_next = ctrl_wr ? wr_ie : timeout_irq_enable_reg;
    if (vector_ack & reset_mode_enable_reg)
      timeout_irq_enable_next = 1'b0;
    if (always_on_fuse)
      timeout_irq_enable_next = 1'b0;
  end

  // irq flag: set wins over clear
  wire irq_set = expire & eff_ie;
  wire irq_clr = vector_ack | (ctrl_wr & ctrl_wdata[BIT_IRQ_FLAG]);
  assign timeout_irq_flag_next = irq_set | (timeout_irq_flag_reg & ~irq_clr);

  // unlock timer: bit clears four cycles after being set, or once spent
  assign unlock_cnt_next = start_unlock ? UNLOCK_CYCLES :
    (unlocked_wr ? 3'h0 :
    (unlock_cnt_reg != 3'h0 ? unlock_cnt_reg - 3'h1 : 3'h0));

  // ==========================================================================
  // time-out action

  // in combined mode the first expiry only flags, a later one resets
  wire irq_first = eff_ie & ~timeout_irq_flag_reg;
  wire fire_reset = expire & eff_en & ~irq_first;

  // reset flag: set by expiry or from outside, set wins over clear
  assign reset_flag_next = fire_reset | (reset_flag_reg & ~reset_flag_clr) | reset_flag_in;

  // interrupt line follows the flag gated by the enable of the same cycle
  assign irq_next = timeout_irq_flag_next & timeout_irq_enable_next;

  // readback image shows the state after this cycle's update
  assign rdata_next = {
    timeout_irq_flag_next,
    timeout_irq_enable_next,
    timeout_select_field_next[3],
    (unlock_cnt_next != 3'h0),
    reset_mode_enable_next,
    timeout_select_field_next[2:0]
  };

  // ==========================================================================
  // registers

  // watchdog counter
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // unlock window counter
  always_ff @(posedge clk) begin
    if (rst) begin
      unlock_cnt_reg <= 3'h0;
    end else begin
      unlock_cnt_reg <= unlock_cnt_next;
    end
  end

  // unlock bit, high while the window is open
  always_ff @(posedge clk) begin
    if (rst) begin
      change_unlock_bit_reg <= 1'h0;
    end else begin
      change_unlock_bit_reg <= (unlock_cnt_next != 3'h0);
    end
  end

  // interrupt enable
  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_irq_enable_reg <= 1'h0;
    end else begin
      timeout_irq_enable_reg <= timeout_irq_enable_next;
    end
  end

  // interrupt flag
  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_irq_flag_reg <= 1'h0;
    end else begin
      timeout_irq_flag_reg <= timeout_irq_flag_next;
    end
  end

  // period select
  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_select_field_reg <= SEL_RESET;
    end else begin
      timeout_select_field_reg <= timeout_select_field_next;
    end
  end

  // reset enable survives system reset, cleared at power-up by rst
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_mode_enable_reg <= 1'h0;
    end else begin
      reset_mode_enable_reg <= reset_mode_enable_next;
    end
  end

  // reset flag survives system reset, cleared at power-up by rst
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_flag_reg <= 1'h0;
    end else begin
      reset_flag_reg <= reset_flag_next;
    end
  end

  // one-cycle system reset pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      sys_reset <= 1'h0;
    end else begin
      sys_reset <= fire_reset;
    end
  end

  // interrupt request line
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'h0;
    end else begin
      irq <= irq_next;
    end
  end

  // control register read back
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_rdata <= 8'h00;
    end else begin
      ctrl_rdata <= rdata_next;
    end
  end

  // reset flag read back
  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_reset_flag <= 1'h0;
    end else begin
      watchdog_reset_flag <= reset_flag_next;
    end
  end

endmodule // ewd_core

//--- ewd_osc_tick.sv
`timescale 1ns/10ps

// divides the cpu clock down to one pulse per low-frequency oscillator cycle
module ewd_osc_tick import ewd_pkg::*; #(
  parameter int DIV = (CLK_KHZ + OSC_KHZ - 1) / OSC_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // tick out
  output logic tick
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  wire wrap = (cnt_reg == 16'(DIV - 1));

  // free running divider
  assign cnt_next = wrap ? 16'h0000 : cnt_reg + 16'h0001;

  // count and pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick <= wrap;
    end
  end

endmodule // ewd_osc_tick

//--- ewd_pkg.sv
package ewd_pkg;

  // ==========================================================================
  // control register bit positions
  localparam int BIT_IRQ_FLAG = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_SEL3 = 5;
  localparam int BIT_UNLOCK = 4;
  localparam int BIT_RST_EN = 3;
  localparam int BIT_SEL2 = 2;
  localparam int BIT_SEL1 = 1;
  localparam int BIT_SEL0 = 0;

  // ==========================================================================
  // reset values and limits
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [3:0] SEL_MAX = 4'h9;
  localparam int BASE_CYCLES_LOG2 = 11;
  localparam int CNT_W = 21;

  // ==========================================================================
  // unlock window in cpu clock cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

  // ==========================================================================
  // oscillator rate in kHz and cpu clock rate in kHz
  localparam int OSC_KHZ = 128;
  localparam int CLK_KHZ = 25000;

  typedef enum logic [1:0] {
    ewd_stopped_type_e,
    ewd_irq_type_e,
    ewd_reset_type_e,
    ewd_both_type_e
  } ewd_mode_type;

endpackage
